// ===== bench/srx_remote.sv
// Purpose: Remote station driving the receive line.
// Assumes: Line is always driven, idle at mark level.
// Notes: Frames are timed in core clock cycles.
`timescale 1ns/1ps
module srx_remote (
  input wire logic clk,
  input wire logic inv,
  output logic rx_line
);
  logic lvl = 1'b1;
  assign rx_line = lvl ^ inv;
  task automatic hold(input logic v, input int n);
    @(posedge clk);
    lvl <= v;
    repeat (n - 1) @(posedge clk);
  endtask : hold
  task automatic send(input logic [8:0] c, input int nb, per, input logic sb);
    hold(1'b0, per);
    for (int i = 0; i < nb; i++) hold(c[i], per);
    hold(sb, per);
    // A gap lets the receiver finish before the next frame.
    hold(1'b1, 2 * per);
  endtask : send
endmodule : srx_remote

// ===== bench/srx_top_props.sv
// Purpose: Port checks of the receive control block.
// Assumes: One clock, reset high.
// Notes: Sees only top ports.
`timescale 1ns/1ps
module srx_top_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [srx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [srx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [srx_pkg::DATA_W-1:0] reg_rdata,
  input wire logic rx_pin_i,
  input wire logic tx_pin_i,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe,
  input wire logic pins_owned,
  input wire logic rx_irq_flag
);
  import srx_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_buf_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rd_buf_q <= 1'b0;
    else rd_buf_q <= reg_rd && reg_addr == OFF_RX_BUF;
  end
  sequence s_off;
    !pins_owned [*2];
  endsequence
  sequence s_buf_rd;
    reg_rd && reg_addr == OFF_RX_BUF && rx_irq_flag;
  endsequence
  sequence s_baud_off;
    s_off ##0 (reg_rd && reg_addr == OFF_BAUD_CTRL);
  endsequence
  property p_oe_off; s_off |-> !tx_pin_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_flag_off; s_off |-> !rx_irq_flag; endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag on");
  property p_flag_rise; $rose(rx_irq_flag) |-> pins_owned; endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rise");
  property p_flag_clr; s_buf_rd |=> !rx_irq_flag; endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag kept");
  property p_flag_fall;
    $fell(rx_irq_flag) |-> rd_buf_q || !pins_owned;
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag lost");
  property p_idle_off; s_baud_off |=> reg_rdata[B_RX_IDLE]; endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle low");
  property p_ovf_off; s_baud_off |=> !reg_rdata[B_AB_OVF]; endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("ovf set");
  property p_err_off;
    s_off ##0 (reg_rd && reg_addr == OFF_RX_CTRL)
      |=> !reg_rdata[B_OVERRUN] && !reg_rdata[B_FRAME_ERR];
  endproperty
  a_err_off: assert property (p_err_off) else $error("err set");
endmodule : srx_top_props
bind srx_top srx_top_props srx_top_props_inst (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin_i(rx_pin_i),
  .tx_pin_i(tx_pin_i), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
  .pins_owned(pins_owned), .rx_irq_flag(rx_irq_flag));

// ===== bench/tb_srx_top.sv
// Purpose: Register and receive tests of the serial block.
// Assumes: 100 MHz clock, no random stimulus.
// Notes: Bit periods are short to keep the run brief.
`timescale 1ns/1ps
module tb_srx_top;
  import srx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic inv = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, d;
  logic rx_line, tx_o, tx_oe, owned, irq;
  int err_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  srx_top srx_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pin_i(rx_line), .tx_pin_i(1'b1),
    .tx_pin_o(tx_o), .tx_pin_oe(tx_oe), .pins_owned(owned),
    .rx_irq_flag(irq));
  srx_remote srx_remote_inst (.clk(clk), .inv(inv), .rx_line(rx_line));
  task chk(input string n, input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task wait_irq(input logic [7:0] e);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 300) begin
      @(posedge clk);
      i++;
    end
    chk("irq", {7'h00, irq}, e);
  endtask : wait_irq
  task rx(input logic [8:0] c, input int nb, per, input logic sb,
      input logic [7:0] ec, eb);
    srx_remote_inst.send(c, nb, per, sb);
    wait_irq(8'h01);
    rd(OFF_RX_CTRL, d);
    chk("rx_ctrl", d, ec);
    rd(OFF_RX_BUF, d);
    chk("rx_buf", d, eb);
    chk("irq_clr", {7'h00, irq}, 8'h00);
  endtask : rx
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_RX_CTRL, d);
    chk("rst_ctrl", d, 8'h00);
    rd(OFF_BAUD_CTRL, d);
    chk("rst_baud", d, 8'h40);
    rd(3'h6, d);
    chk("unmapped", d, 8'h00);
    wr(OFF_BAUD_CTRL, 8'hff);
    rd(OFF_BAUD_CTRL, d);
    chk("baud_ro", d, 8'h7b);
    $display("test regs done");
    wr(OFF_BAUD_CTRL, 8'h08);
    wr(OFF_MODE_CTRL, 8'h04);
    wr(OFF_DIV_HIGH, 8'h00);
    wr(OFF_DIV_LOW, 8'h03);
    wr(OFF_RX_CTRL, 8'h90);
    #1 chk("owned", {7'h00, owned}, 8'h01);
    rx(9'h0a5, 8, 16, 1'b1, 8'h90, 8'ha5);
    rx(9'h033, 8, 16, 1'b0, 8'h94, 8'h33);
    rx(9'h05a, 8, 16, 1'b1, 8'h90, 8'h5a);
    wr(OFF_RX_CTRL, 8'hd8);
    srx_remote_inst.send(9'h055, 9, 16, 1'b1);
    wait_irq(8'h00);
    rx(9'h1c3, 9, 16, 1'b1, 8'hd9, 8'hc3);
    wr(OFF_RX_CTRL, 8'hd0);
    rx(9'h0c3, 9, 16, 1'b1, 8'hd0, 8'hc3);
    wr(OFF_RX_CTRL, 8'h98);
    rx(9'h1e1, 8, 16, 1'b1, 8'h98, 8'he1);
    $display("test frames done");
    wr(OFF_RX_CTRL, 8'h90);
    srx_remote_inst.send(9'h0a1, 8, 16, 1'b1);
    srx_remote_inst.send(9'h0b2, 8, 16, 1'b1);
    rd(OFF_RX_CTRL, d);
    chk("ovr_set", d, 8'h92);
    rd(OFF_RX_BUF, d);
    chk("ovr_buf", d, 8'ha1);
    wr(OFF_RX_CTRL, 8'h80);
    rd(OFF_RX_CTRL, d);
    chk("ovr_clr", d, 8'h80);
    // Receiver is off while the line level flips to avoid a false start.
    wr(OFF_BAUD_CTRL, 8'h28);
    inv <= 1'b1;
    repeat (20) @(posedge clk);
    wr(OFF_RX_CTRL, 8'h90);
    rx(9'h0f0, 8, 16, 1'b1, 8'h90, 8'hf0);
    wr(OFF_RX_CTRL, 8'h80);
    wr(OFF_BAUD_CTRL, 8'h00);
    inv <= 1'b0;
    wr(OFF_MODE_CTRL, 8'h00);
    wr(OFF_DIV_LOW, 8'h00);
    repeat (20) @(posedge clk);
    wr(OFF_RX_CTRL, 8'h90);
    rx(9'h03c, 8, 64, 1'b1, 8'h90, 8'h3c);
    $display("test rates done");
    wr(OFF_BAUD_CTRL, 8'h12);
    srx_remote_inst.hold(1'b0, 40);
    wait_irq(8'h01);
    srx_remote_inst.hold(1'b1, 40);
    rd(OFF_BAUD_CTRL, d);
    chk("wake_clr", {7'h00, d[1]}, 8'h00);
    chk("tx_pin", {6'h00, tx_oe, tx_o}, 8'h02);
    wr(OFF_BAUD_CTRL, 8'h01);
    srx_remote_inst.hold(1'b0, 20);
    srx_remote_inst.hold(1'b1, 20);
    rd(OFF_BAUD_CTRL, d);
    chk("ab_done", d, 8'h40);
    wr(OFF_RX_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    chk("owned_off", {7'h00, owned}, 8'h00);
    chk("irq_off", {7'h00, irq}, 8'h00);
    $display("test wake done");
    // Line stays high, so a single master receive must give all ones.
    wr(OFF_MODE_CTRL, 8'h90);
    wr(OFF_RX_CTRL, 8'ha0);
    wait_irq(8'h01);
    rd(OFF_RX_CTRL, d);
    chk("sync_ctrl", d, 8'h80);
    rd(OFF_RX_BUF, d);
    chk("sync_buf", d, 8'hff);
    $display("test sync done");
    finish_test();
  end
endmodule : tb_srx_top

// ===== src/srx_baud_gen.sv
// Purpose: Free-running baud timer giving four quarter ticks per bit.
// Assumes: Divisor and mode bits are stable register outputs.
// Notes: A clear restarts both the divisor count and the prescaler.
`timescale 1ns/1ps
module srx_baud_gen #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic sync_mode,
  input wire logic wide,
  input wire logic high_speed,
  output logic q_tick
);
  import srx_pkg::*;

  logic [DIV_W-1:0] cnt_reg;
  logic [3:0] pre_reg;
  logic base_ovf;
  logic [3:0] pre_last;

  assign base_ovf = (cnt_reg == divisor);
  assign pre_last = srx_pre_last(sync_mode, wide, high_speed);

  // (R18) Free-running timer.
  // (R20) Divisor write restarts.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (clear || base_ovf) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // (R21) Period multiplier prescale.
  // (R22) High-speed multipliers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 4'h0;
      q_tick <= 1'b0;
    end else if (clear) begin
      pre_reg <= 4'h0;
      q_tick <= 1'b0;
    end else begin
      q_tick <= base_ovf && (pre_reg >= pre_last);
      if (base_ovf) begin
        pre_reg <= (pre_reg >= pre_last) ? 4'h0 : pre_reg + 4'h1;
      end
    end
  end

endmodule : srx_baud_gen

// ===== src/srx_pkg.sv
// Purpose: Shared constants for the serial receive control and baud timer.
// Assumes: Register port with a 3-bit word address and 8-bit data.
// Notes: Every offset, field position and count used by the logic is here.
package srx_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register word offsets.
  localparam logic [ADDR_W-1:0] OFF_RX_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_BAUD_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_DIV_LOW = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_DIV_HIGH = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_RX_BUF = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_MODE_CTRL = 3'h5;

  // Field positions of rx_ctrl_status.
  localparam int B_PORT_ON = 7;
  localparam int B_NINE_BIT = 6;
  localparam int B_SINGLE_RX = 5;
  localparam int B_CONT_RX = 4;
  localparam int B_ADDR_DET = 3;
  localparam int B_FRAME_ERR = 2;
  localparam int B_OVERRUN = 1;
  localparam int B_NINTH = 0;

  // Field positions of baud_ctrl.
  localparam int B_AB_OVF = 7;
  localparam int B_RX_IDLE = 6;
  localparam int B_RX_INV = 5;
  localparam int B_CLK_POL = 4;
  localparam int B_WIDE_DIV = 3;
  localparam int B_WAKE = 1;
  localparam int B_AB_ON = 0;

  // Field positions of mode_ctrl.
  localparam int B_CLK_MASTER = 7;
  localparam int B_SYNC_MODE = 4;
  localparam int B_HIGH_SPEED = 2;

  // Reset values.
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [1:0] PIN_IDLE = 2'h3;

  // Each bit period is four quarter ticks of the baud timer.
  localparam logic [1:0] QTR_MID = 2'h1;
  localparam logic [1:0] QTR_LAST = 2'h3;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  // Last prescale count per quarter tick: period multiplier divided by 4, less one.
  localparam logic [3:0] PRE_64 = 4'hf;
  localparam logic [3:0] PRE_16 = 4'h3;
  localparam logic [3:0] PRE_4 = 4'h0;

  localparam logic [15:0] AB_CNT_MAX = 16'hffff;

  // Last prescale count for the selected speed and divider width.
  function automatic logic [3:0] srx_pre_last(
    input logic sync_mode,
    input logic wide,
    input logic high_speed
  );
    if (sync_mode) begin
      srx_pre_last = PRE_4;
    end else if (!wide && !high_speed) begin
      srx_pre_last = PRE_64;
    end else if (wide && high_speed) begin
      srx_pre_last = PRE_4;
    end else begin
      srx_pre_last = PRE_16;
    end
  endfunction : srx_pre_last

endpackage : srx_pkg

// ===== src/srx_top.sv
// Purpose: Receive control, status and baud timer of a serial port.
// Assumes: One core clock; pins are synchronised inside this block.
// Notes: Transmit data path and the auto-baud rate search are not here.
//
// Behaviour
// (R1) Port-on gives pins; off resets unit.
// (R2) Nine-bit bit selects 9-bit reception.
// (R3) Single receive in sync master, self-clearing.
// (R4) Continuous receive enables, overrides single.
// (R5) Address detect buffers only ninth-bit-one characters.
// (R6) Detect off buffers all; ignored 8-bit.
// (R7) Framing flag follows buffered character.
// (R8) Overrun flag cleared by clearing continuous.
// (R9) Ninth bit shown; parity left to software.
// (R10) Auto-baud timer overflow sets flag.
// (R11) Idle flag low while receiver active.
// (R12) Polarity bit inverts the receive line.
// (R13) Transmit idle low when polarity set.
// (R14) Sync clock polarity picks sample edge.
// (R15) Width bit selects 16 or 8-bit divisor.
// (R16) Wake-on-edge flags fall, clears on rise.
// (R17) Auto-baud enable starts, clears when done.
// (R18) Baud timer free-runs from core clock.
// (R19) High-speed bit ignored in sync mode.
// (R20) Divisor write clears baud timer.
// (R21) Divide by 64, 16 or 4 times.
// (R22) High speed divides by 16 or 4.
// (R23) Sync select picks mode interpretation.
// (R24) Receiver samples mid-bit, flags bad stop.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module srx_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [srx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [srx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [srx_pkg::DATA_W-1:0] reg_rdata,
  input wire logic rx_pin_i,
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe,
  output logic pins_owned,
  output logic rx_irq_flag
);
  import srx_pkg::*;

  typedef enum logic [2:0] {
    SRX_IDLE = 3'b000,
    SRX_START = 3'b001,
    SRX_DATA = 3'b010,
    SRX_STOP = 3'b011,
    SRX_SYNC = 3'b100
  } srx_state_e;

  function automatic logic srx_hit(
    input logic strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    srx_hit = strobe && (addr == off);
  endfunction : srx_hit

  // Control bits written by software.
  logic port_on_reg, nine_bit_rx_reg, single_rx_req_reg, cont_rx_on_reg;
  logic addr_detect_on_reg, rx_polarity_invert_reg, tx_clk_polarity_reg;
  logic wide_divider_sel_reg, wake_on_edge_reg, autobaud_on_reg;
  logic sync_mode_reg, high_speed_sel_reg, clk_master_reg;
  logic [DATA_W-1:0] divisor_low_reg, divisor_high_reg;
  // Status kept by hardware.
  logic frame_err_flag_reg, overrun_flag_reg, rx_ninth_bit_reg;
  logic autobaud_overflow_reg, rx_irq_flag_reg;
  logic [DATA_W-1:0] rx_buffer_reg;
  // Receiver.
  srx_state_e state_reg;
  logic [1:0] qcnt_reg;
  logic [3:0] bitcnt_reg;
  logic [8:0] rx_shift_reg;
  logic done_reg, done_frame_err_flag_reg;
  // Pins.
  logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
  logic line_prev_reg, clk_prev_reg, wake_fell_reg;
  logic [15:0] ab_cnt_reg;
  logic ab_run_reg;
  logic [DATA_W-1:0] rdata_mux;

  logic wr_rx_ctrl, wr_baud, wr_div_lo, wr_div_hi, wr_mode, rd_buf;
  logic unit_off, async_mode, line_now, fall, rise, clk_in;
  logic async_en, master_run, slave_run, slave_sample, q_tick;
  logic [3:0] nbits_last;
  logic ninth_in, accept, wake_event, wake_clear, ab_active, ab_done;
  logic rx_idle_flag, sync_sample;

  assign wr_rx_ctrl = srx_hit(reg_wr, reg_addr, OFF_RX_CTRL);
  assign wr_baud = srx_hit(reg_wr, reg_addr, OFF_BAUD_CTRL);
  assign wr_div_lo = srx_hit(reg_wr, reg_addr, OFF_DIV_LOW);
  assign wr_div_hi = srx_hit(reg_wr, reg_addr, OFF_DIV_HIGH);
  assign wr_mode = srx_hit(reg_wr, reg_addr, OFF_MODE_CTRL);
  assign rd_buf = srx_hit(reg_rd, reg_addr, OFF_RX_BUF);

  // (R1) Off holds unit in reset.
  assign unit_off = !port_on_reg;
  // (R23) Mode select.
  assign async_mode = port_on_reg && !sync_mode_reg;

  // Three stages; a level is taken once stages two and three agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= PIN_IDLE;
      pin_s2_reg <= PIN_IDLE;
      pin_s3_reg <= PIN_IDLE;
      pin_lvl_reg <= PIN_IDLE;
    end else begin
      pin_s1_reg <= {tx_pin_i, rx_pin_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_lvl_reg <= (pin_s2_reg & pin_s3_reg)
                     | (pin_lvl_reg & (pin_s2_reg | pin_s3_reg));
    end
  end

  // (R12) Receive line polarity.
  assign line_now = pin_lvl_reg[0] ^ rx_polarity_invert_reg;
  assign clk_in = pin_lvl_reg[1];
  assign fall = line_prev_reg && !line_now;
  assign rise = !line_prev_reg && line_now;

  // (R14) Sample on edge returning to idle.
  assign slave_sample = (clk_prev_reg != clk_in)
                        && (clk_in == tx_clk_polarity_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_prev_reg <= 1'b1;
      clk_prev_reg <= 1'b1;
    end else begin
      line_prev_reg <= line_now;
      clk_prev_reg <= clk_in;
    end
  end

  // (R4) Continuous enables async receiver.
  assign async_en = async_mode && cont_rx_on_reg && !wake_on_edge_reg
                    && !autobaud_on_reg;
  // (R3) Single receive only in master.
  assign master_run = port_on_reg && sync_mode_reg && clk_master_reg
                      && (cont_rx_on_reg || single_rx_req_reg);
  assign slave_run = port_on_reg && sync_mode_reg && !clk_master_reg
                     && cont_rx_on_reg;
  // (R2) Character length.
  assign nbits_last = nine_bit_rx_reg ? BITS_9 - 4'h1 : BITS_8 - 4'h1;
  assign sync_sample = clk_master_reg ? (q_tick && qcnt_reg == QTR_LAST)
                                      : slave_sample;

  srx_baud_gen #(
    .DIV_W(16)
  ) u_baud (
    .clk(clk),
    .rst(rst),
    .clear(wr_div_lo || wr_div_hi || unit_off),
    // (R15) Divider width.
    .divisor(wide_divider_sel_reg ? {divisor_high_reg, divisor_low_reg}
                                  : {RST_BYTE, divisor_low_reg}),
    .sync_mode(sync_mode_reg),
    .wide(wide_divider_sel_reg),
    // (R19) High speed only async.
    .high_speed(high_speed_sel_reg && !sync_mode_reg),
    .q_tick(q_tick)
  );

  // (R24) Receive state machine.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SRX_IDLE;
      qcnt_reg <= 2'h0;
      bitcnt_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      done_reg <= 1'b0;
      done_frame_err_flag_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (unit_off) begin
        state_reg <= SRX_IDLE;
        qcnt_reg <= 2'h0;
      end else begin
        case (state_reg)
          SRX_IDLE: begin
            qcnt_reg <= 2'h0;
            bitcnt_reg <= 4'h0;
            if (async_en && fall) begin
              state_reg <= SRX_START;
            end else if (master_run || slave_run) begin
              state_reg <= SRX_SYNC;
            end
          end
          SRX_START: begin
            if (!async_en) begin
              state_reg <= SRX_IDLE;
            end else if (q_tick) begin
              qcnt_reg <= qcnt_reg + 2'h1;
              // (R24) Start bit checked mid-bit.
              if (qcnt_reg == QTR_MID) begin
                qcnt_reg <= 2'h0;
                state_reg <= line_now ? SRX_IDLE : SRX_DATA;
              end
            end
          end
          SRX_DATA: begin
            if (!async_en) begin
              state_reg <= SRX_IDLE;
            end else if (q_tick) begin
              qcnt_reg <= qcnt_reg + 2'h1;
              if (qcnt_reg == QTR_LAST) begin
                rx_shift_reg <= {line_now, rx_shift_reg[8:1]};
                bitcnt_reg <= bitcnt_reg + 4'h1;
                if (bitcnt_reg == nbits_last) begin
                  state_reg <= SRX_STOP;
                end
              end
            end
          end
          SRX_STOP: begin
            if (!async_en) begin
              state_reg <= SRX_IDLE;
            end else if (q_tick) begin
              qcnt_reg <= qcnt_reg + 2'h1;
              if (qcnt_reg == QTR_LAST) begin
                // (R24) Low stop bit is framing error.
                done_reg <= 1'b1;
                done_frame_err_flag_reg <= !line_now;
                state_reg <= SRX_IDLE;
              end
            end
          end
          SRX_SYNC: begin
            if (!(master_run || slave_run)) begin
              state_reg <= SRX_IDLE;
            end else begin
              if (q_tick) begin
                qcnt_reg <= qcnt_reg + 2'h1;
              end
              if (sync_sample) begin
                rx_shift_reg <= {line_now, rx_shift_reg[8:1]};
                bitcnt_reg <= bitcnt_reg + 4'h1;
                if (bitcnt_reg == nbits_last) begin
                  done_reg <= 1'b1;
                  done_frame_err_flag_reg <= 1'b0;
                  state_reg <= SRX_IDLE;
                end
              end
            end
          end
          default: begin
            state_reg <= SRX_IDLE;
          end
        endcase
      end
    end
  end

  // (R11) Idle while no character is in progress.
  assign rx_idle_flag = (state_reg == SRX_IDLE);
  assign ninth_in = nine_bit_rx_reg && rx_shift_reg[8];
  // (R5) Address detect filter.
  // (R6) Ignored for 8-bit or sync.
  assign accept = done_reg && !(nine_bit_rx_reg && addr_detect_on_reg
                                && !sync_mode_reg && !rx_shift_reg[8]);
  // (R16) Falling edge wakes.
  assign wake_event = async_mode && wake_on_edge_reg && fall;
  assign wake_clear = async_mode && wake_on_edge_reg && wake_fell_reg
                      && rise;

  // One-character buffer; a character that finds it full is an overrun.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buffer_reg <= RST_BYTE;
      frame_err_flag_reg <= 1'b0;
      rx_ninth_bit_reg <= 1'b0;
      rx_irq_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
    end else if (unit_off) begin
      frame_err_flag_reg <= 1'b0;
      rx_irq_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
    end else begin
      if (accept && rx_irq_flag_reg && !rd_buf) begin
        overrun_flag_reg <= 1'b1;
      end else if (!cont_rx_on_reg) begin
        // (R8) Cleared by clearing continuous.
        overrun_flag_reg <= 1'b0;
      end
      if (accept && !(rx_irq_flag_reg && !rd_buf)) begin
        rx_buffer_reg <= nine_bit_rx_reg ? rx_shift_reg[7:0]
                                         : rx_shift_reg[8:1];
        // (R7) Flag travels with character.
        frame_err_flag_reg <= done_frame_err_flag_reg;
        // (R9) Ninth bit passed unchanged.
        rx_ninth_bit_reg <= ninth_in;
        rx_irq_flag_reg <= 1'b1;
      end else if (wake_event) begin
        rx_irq_flag_reg <= 1'b1;
      end else if (rd_buf) begin
        rx_irq_flag_reg <= 1'b0;
      end
    end
  end

  // (R16) Remember fall until rise.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_fell_reg <= 1'b0;
    end else if (!(async_mode && wake_on_edge_reg)) begin
      wake_fell_reg <= 1'b0;
    end else if (fall) begin
      wake_fell_reg <= 1'b1;
    end
  end

  // (R17) Auto-baud window is start edge to next rise.
  assign ab_active = async_mode && autobaud_on_reg;
  assign ab_done = ab_active && ab_run_reg && rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ab_run_reg <= 1'b0;
      ab_cnt_reg <= 16'h0000;
      autobaud_overflow_reg <= 1'b0;
    end else begin
      if (!ab_active || ab_done) begin
        ab_run_reg <= 1'b0;
      end else if (fall) begin
        ab_run_reg <= 1'b1;
        ab_cnt_reg <= 16'h0000;
      end else if (ab_run_reg) begin
        ab_cnt_reg <= ab_cnt_reg + 16'h0001;
      end
      // (R10) Overflow flag, set wins.
      if (ab_active && ab_run_reg && ab_cnt_reg == AB_CNT_MAX) begin
        autobaud_overflow_reg <= 1'b1;
      end else if (unit_off || (wr_baud && reg_wdata[B_AB_ON])) begin
        autobaud_overflow_reg <= 1'b0;
      end
    end
  end

  // Software-written control; a write wins over a hardware clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_on_reg <= 1'b0;
      nine_bit_rx_reg <= 1'b0;
      single_rx_req_reg <= 1'b0;
      cont_rx_on_reg <= 1'b0;
      addr_detect_on_reg <= 1'b0;
      rx_polarity_invert_reg <= 1'b0;
      tx_clk_polarity_reg <= 1'b0;
      wide_divider_sel_reg <= 1'b0;
      wake_on_edge_reg <= 1'b0;
      autobaud_on_reg <= 1'b0;
      sync_mode_reg <= 1'b0;
      high_speed_sel_reg <= 1'b0;
      clk_master_reg <= 1'b0;
      divisor_low_reg <= RST_BYTE;
      divisor_high_reg <= RST_BYTE;
    end else begin
      if (wr_rx_ctrl) begin
        port_on_reg <= reg_wdata[B_PORT_ON];
        nine_bit_rx_reg <= reg_wdata[B_NINE_BIT];
        single_rx_req_reg <= reg_wdata[B_SINGLE_RX];
        cont_rx_on_reg <= reg_wdata[B_CONT_RX];
        addr_detect_on_reg <= reg_wdata[B_ADDR_DET];
      end else if (done_reg && sync_mode_reg && clk_master_reg) begin
        // (R3) Single request ends.
        single_rx_req_reg <= 1'b0;
      end
      if (wr_baud) begin
        rx_polarity_invert_reg <= reg_wdata[B_RX_INV];
        tx_clk_polarity_reg <= reg_wdata[B_CLK_POL];
        wide_divider_sel_reg <= reg_wdata[B_WIDE_DIV];
        wake_on_edge_reg <= reg_wdata[B_WAKE];
        autobaud_on_reg <= reg_wdata[B_AB_ON];
      end else begin
        if (wake_clear) begin
          wake_on_edge_reg <= 1'b0;
        end
        if (ab_done) begin
          autobaud_on_reg <= 1'b0;
        end
      end
      if (wr_mode) begin
        clk_master_reg <= reg_wdata[B_CLK_MASTER];
        sync_mode_reg <= reg_wdata[B_SYNC_MODE];
        high_speed_sel_reg <= reg_wdata[B_HIGH_SPEED];
      end
      if (wr_div_lo) begin
        divisor_low_reg <= reg_wdata;
      end
      if (wr_div_hi) begin
        divisor_high_reg <= reg_wdata;
      end
    end
  end

  // (R13) Async transmit idles at the inverse of the polarity bit.
  // (R14) Master clock leaves idle mid-bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pin_o <= 1'b1;
      tx_pin_oe <= 1'b0;
    end else begin
      // (R1) Pins owned only while on.
      tx_pin_oe <= port_on_reg && (!sync_mode_reg || clk_master_reg);
      if (!sync_mode_reg) begin
        tx_pin_o <= !tx_clk_polarity_reg;
      end else if (state_reg == SRX_SYNC && qcnt_reg[1]) begin
        tx_pin_o <= !tx_clk_polarity_reg;
      end else begin
        tx_pin_o <= tx_clk_polarity_reg;
      end
    end
  end

  always_comb begin
    rdata_mux = RST_BYTE;
    case (reg_addr)
      OFF_RX_CTRL: begin
        rdata_mux = {port_on_reg, nine_bit_rx_reg, single_rx_req_reg,
                     cont_rx_on_reg, addr_detect_on_reg, frame_err_flag_reg,
                     overrun_flag_reg, rx_ninth_bit_reg};
      end
      OFF_BAUD_CTRL: begin
        rdata_mux = {autobaud_overflow_reg, rx_idle_flag,
                     rx_polarity_invert_reg, tx_clk_polarity_reg,
                     wide_divider_sel_reg, 1'b0, wake_on_edge_reg,
                     autobaud_on_reg};
      end
      OFF_DIV_LOW: begin
        rdata_mux = divisor_low_reg;
      end
      OFF_DIV_HIGH: begin
        rdata_mux = divisor_high_reg;
      end
      OFF_RX_BUF: begin
        rdata_mux = rx_buffer_reg;
      end
      OFF_MODE_CTRL: begin
        rdata_mux[B_CLK_MASTER] = clk_master_reg;
        rdata_mux[B_SYNC_MODE] = sync_mode_reg;
        rdata_mux[B_HIGH_SPEED] = high_speed_sel_reg;
      end
      default: begin
        rdata_mux = RST_BYTE;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rdata_mux : RST_BYTE;
    end
  end

  assign pins_owned = port_on_reg;
  assign rx_irq_flag = rx_irq_flag_reg;

endmodule : srx_top
